// ---- bench/remote_ctrl_model.sv ----
`timescale 1ns/1ps
module remote_ctrl_model #(
    parameter int MS = 4 // cycles standing in for one millisecond
) (
    input wire logic                mclk,         // clock
    input wire logic                link_present, // link
    input wire logic                busy,         // busy
    input wire remote_pkg::mode_e   mode,         // variant
    output remote_pkg::strobe_s     sn            // strobes, active low
);
    int idle_cyc = 0;
    int link_cyc = 0;
    logic [remote_pkg::STROBE_W-1:0] low = '0; // strobes now held low
    assign sn = remote_pkg::strobe_s'(~low);
    always @(posedge mclk) begin
        idle_cyc <= busy ? 0 : idle_cyc + 1;
        link_cyc <= link_present ? link_cyc + 1 : 0;
    end
    function automatic int gap(input int i);
        if (i == 3) return (mode == remote_pkg::MODE_BANK) ? 5 : 1;
        return (i < 3) ? 10 : (i == 4) ? 1 : 0;
    endfunction
    task automatic fall(input int i);
        @(posedge mclk);
        while (link_cyc < MS || idle_cyc < gap(i) * MS) @(posedge mclk);
        #1 low[i] = 1'h1;
    endtask
    task automatic rise(input int i);
        repeat (50 * MS) @(posedge mclk);
        #1 low[i] = 1'h0;
        repeat (MS) @(posedge mclk);
        #1;
    endtask
endmodule

// ---- bench/remote_monitor.sv ----
`timescale 1ns/1ps
module remote_monitor #(
    parameter int unsigned PREP_LIMIT = 50
) (
    input wire logic              mclk,         // clock
    input wire logic              rst_n,        // reset
    input wire remote_pkg::mode_e mode,         // variant
    input wire logic              verify_cmd_n, // strobe
    input wire logic              start_n,      // strobe
    input wire logic              enter_n,      // strobe
    input wire logic              clear_n,      // strobe
    input wire logic              area_changed, // area flag
    input wire logic              prep_done,    // reload end
    input wire logic              op_done,      // op end
    input wire logic              op_pass,      // op result
    input wire logic              link_present, // link
    input wire logic              busy,         // busy
    input wire logic              pass,         // pass
    input wire logic              error,        // error
    input wire logic              op_start,     // start pulse
    input wire logic              prep_req      // reload wait
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic        cmd_n;
    logic [31:0] prep_cnt;
    assign cmd_n = verify_cmd_n & start_n & enter_n;
    // length of the current reload wait
    always_ff @(posedge mclk) begin
        prep_cnt <= (rst_n && prep_req) ? prep_cnt + 32'h1 : 32'h0;
    end
    sequence take;
        $fell(cmd_n) && link_present && !busy && !prep_req;
    endsequence
    AST_STD_BUSY: assert property (take ##0 (mode == remote_pkg::MODE_STANDARD)
        |-> ##2 (busy && op_start)) else $error("busy late in standard mode");
    AST_BANK_BUSY: assert property (take ##0 (mode == remote_pkg::MODE_BANK)
        |-> ##2 busy) else $error("busy late in bank mode");
    AST_SIMPLE_FAST: assert property (take ##0 (mode == remote_pkg::MODE_SIMPLE
        && !area_changed) |-> ##2 busy) else $error("busy late in simple mode");
    AST_SIMPLE_PREP: assert property (take ##0 (mode == remote_pkg::MODE_SIMPLE
        && area_changed) |-> ##2 (prep_req && !busy)) else $error("no reload wait");
    AST_PREP_BOUND: assert property (prep_cnt <= PREP_LIMIT + 32'h1)
        else $error("reload wait too long");
    AST_CLEAR_DROP: assert property ($fell(clear_n) && link_present
        ##1 !(op_done && busy) && !prep_req |-> ##1 (!pass && !error))
        else $error("result not cleared");
    AST_DONE_RESULT: assert property (op_done && busy
        |-> ##1 (!busy && pass == $past(op_pass) && error != $past(op_pass)))
        else $error("bad result");
    AST_RESULT_HOLD: assert property ((pass || error) && !busy && clear_n
        && $past(clear_n) && cmd_n && $past(cmd_n) |=> $stable({pass, error}))
        else $error("result not held");
    cover property (take ##0 (mode == remote_pkg::MODE_BANK));
    cover property (prep_req && prep_done);
    cover property ($fell(clear_n) && error);
endmodule
bind remote_control_handshake remote_monitor #(.PREP_LIMIT(PREP_LIMIT)) u_mon (
    .mclk, .rst_n, .mode, .verify_cmd_n, .start_n, .enter_n, .clear_n,
    .area_changed, .prep_done, .op_done, .op_pass, .link_present, .busy,
    .pass, .error, .op_start, .prep_req);

// ---- bench/tb_remote_control_handshake.sv ----
`timescale 1ns/1ps
module tb_remote_control_handshake;
    localparam int unsigned PREP = 50;
    logic                mclk, rst_n, link_ready, area_changed, prep_done, op_done, op_pass;
    logic                link_present, busy, pass, error, op_start, op_abort, area_next;
    logic                prep_req;
    logic [2:0]          op_bank;
    remote_pkg::mode_e   mode;
    remote_pkg::op_e     op_kind;
    remote_pkg::strobe_s sn;
    int                  err_count = 0;
    int                  n_tests = 0;
    remote_control_handshake #(.PREP_LIMIT(PREP)) DUT (
        .mclk, .rst_n, .mode, .link_ready, .verify_cmd_n(sn.verify_cmd),
        .start_n(sn.start), .enter_n(sn.enter), .cancel_n(sn.cancel),
        .next_n(sn.next), .clear_n(sn.clear), .bank_select_n(sn.bank),
        .area_changed, .prep_done, .op_done, .op_pass, .link_present, .busy,
        .pass, .error, .op_start, .op_kind, .op_bank, .op_abort, .area_next, .prep_req);
    remote_ctrl_model u_ctrl (.mclk, .link_present, .busy, .mode, .sn);
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic step2();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic cmd(input int i);
        u_ctrl.fall(i);
        step2();
        chk("busy", 3'h1, busy);
        chk("op_start", 3'h1, op_start);
        chk("op_kind", 3'(8 - i), op_kind);
        u_ctrl.rise(i);
    endtask
    task automatic end_op(input logic ok);
        op_done = 1'h1;
        op_pass = ok;
        @(posedge mclk);
        #1 op_done = 1'h0;
        @(posedge mclk);
        #1;
        chk("busy", 3'h0, busy);
        chk("pass", {2'h0, ok}, pass);
        chk("error", {2'h0, !ok}, error);
    endtask
    task automatic clr();
        u_ctrl.fall(3);
        step2();
        chk("pass", 3'h0, pass);
        chk("error", 3'h0, error);
        u_ctrl.rise(3);
    endtask
    task automatic t_standard();
        mode = remote_pkg::MODE_STANDARD;
        for (int i = 8; i >= 6; i--) begin
            cmd(i);
            end_op(i[0]);
        end
        clr();
    endtask
    task automatic t_bank();
        mode = remote_pkg::MODE_BANK;
        u_ctrl.fall(1);
        u_ctrl.rise(1);
        cmd(7);
        chk("op_bank", 3'h2, op_bank);
        u_ctrl.fall(5);
        step2();
        chk("op_abort", 3'h1, op_abort);
        u_ctrl.rise(5);
        end_op(1'h0);
        clr();
    endtask
    task automatic t_simple();
        mode = remote_pkg::MODE_SIMPLE;
        u_ctrl.fall(4);
        step2();
        chk("area_next", 3'h1, area_next);
        u_ctrl.rise(4);
        cmd(8);
        end_op(1'h1);
        area_changed = 1'h1;
        u_ctrl.fall(7);
        step2();
        chk("prep_req", 3'h1, prep_req);
        chk("busy", 3'h0, busy);
        prep_done = 1'h1;
        @(posedge mclk);
        #1 prep_done = 1'h0;
        @(posedge mclk);
        #1;
        chk("busy", 3'h1, busy);
        u_ctrl.rise(7);
        end_op(1'h1);
        u_ctrl.fall(6);
        repeat (PREP) @(posedge mclk);
        #1;
        chk("prep_req", 3'h1, prep_req);
        chk("busy", 3'h0, busy);
        repeat (4) @(posedge mclk);
        #1;
        chk("busy", 3'h1, busy);
        u_ctrl.rise(6);
        end_op(1'h0);
        clr();
        u_ctrl.fall(8);
        step2();
        chk("prep_req", 3'h1, prep_req);
        u_ctrl.fall(5);
        step2();
        chk("prep_req", 3'h0, prep_req);
        chk("error", 3'h1, error);
        u_ctrl.rise(5);
        u_ctrl.rise(8);
        clr();
    endtask
    task automatic t_link();
        link_ready = 1'h0;
        @(posedge mclk);
        #1;
        chk("link_present", 3'h0, link_present);
        rst_n = 1'h0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'h1;
        chk("op_bank", 3'h1, op_bank);
        chk("busy", 3'h0, busy);
        link_ready = 1'h1;
        @(posedge mclk);
        #1;
        chk("link_present", 3'h1, link_present);
    endtask
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
    initial begin
        rst_n = 1'h0;
        mode = remote_pkg::MODE_STANDARD;
        link_ready = 1'h1;
        area_changed = 1'h0;
        prep_done = 1'h0;
        op_done = 1'h0;
        op_pass = 1'h0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'h1;
        t_standard();
        t_bank();
        t_link();
        t_simple();
        give_verdict();
    end
endmodule

// ---- rtl/remote_control_handshake.sv ----
// What this block and its controller do
// R1: controller holds each command strobe low at least 50 ms.
// R2: controller waits 1 ms after link_present rises before any strobe.
// R3: standard mode raises busy within 50 ms of a command fall.
// R4: bank mode raises busy within 100 ms of a command fall.
// R5: simple mode with changed area raises busy within 8000 ms.
// R6: simple mode with unchanged area raises busy within 50 ms.
// R7: standard and simple: controller waits 1 ms after busy falls before clear.
// R8: bank mode: controller waits 5 ms after busy falls before clear.
// R9: pass or error drops within 50 ms of a clear fall.
// R10: standard mode accepts a new command within 1 ms of busy falling.
// R11: bank mode: controller waits 10 ms after busy falls before bank selects.
// R12: bank mode: controller waits 1 ms after bank select before command.
// R13: simple mode: controller waits 1 ms after next before command.
// R14: simple mode: controller waits 1 ms after busy falls before next.
// R15: at busy fall exactly one of pass or error is held until clear; the block also drops it when it takes a new command.
`timescale 1ns/1ps

module remote_control_handshake #(
    parameter int unsigned PREP_LIMIT = remote_pkg::PREP_MAX_CYCLES
) (
    input  wire logic              mclk,          // system clock, 25 MHz
    input  wire logic              rst_n,         // synchronous reset, active low
    input  wire remote_pkg::mode_e mode,          // operating variant
    input  wire logic              link_ready,    // instrument ready for remote use
    input  wire logic              verify_cmd_n,  // verify strobe, active low
    input  wire logic              start_n,       // start strobe, active low
    input  wire logic              enter_n,       // enter strobe, active low
    input  wire logic              cancel_n,      // cancel strobe, active low
    input  wire logic              next_n,        // next-area strobe, active low
    input  wire logic              clear_n,       // result clear strobe, active low
    input  wire logic [2:0]        bank_select_n, // bank selects 0..2, active low
    input  wire logic              area_changed,  // program area changed since last run
    input  wire logic              prep_done,     // area reload finished
    input  wire logic              op_done,       // operation finished, one-cycle pulse
    input  wire logic              op_pass,       // result with op_done, high on success
    output logic                   link_present,  // connection-present output
    output logic                   busy,          // operation in progress
    output logic                   pass,          // last operation succeeded
    output logic                   error,         // last operation failed
    output logic                   op_start,      // start the operation, one-cycle pulse
    output remote_pkg::op_e        op_kind,       // which command was taken
    output logic [2:0]             op_bank,       // selected bank, one-hot
    output logic                   op_abort,      // cancel while busy, one-cycle pulse
    output logic                   area_next,     // advance program area, one-cycle pulse
    output logic                   prep_req       // area reload in progress
);

    typedef struct packed {
        remote_pkg::state_e          st;
        logic [remote_pkg::PREP_CNT_W-1:0] cnt;
        logic                        link;
        logic                        busy;
        logic                        pass;
        logic                        error;
        logic                        op_start;
        remote_pkg::op_e             kind;
        logic [2:0]                  bank;
        logic                        abort;
        logic                        area_next;
        logic                        prep_req;
    } ctl_s;

    localparam logic [remote_pkg::PREP_CNT_W-1:0] PREP_LAST =
        remote_pkg::PREP_CNT_W'(PREP_LIMIT - 1);

    ctl_s                r;
    ctl_s                next_r;
    remote_pkg::strobe_s f;
    logic                cmd;

    // strobes count only once the link is announced
    strobe_edge #(
        .N(remote_pkg::STROBE_W)
    ) u_edge (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (r.link),
        .strobe_n ({verify_cmd_n, start_n, enter_n, cancel_n, next_n, clear_n,
                    bank_select_n}),
        .fall     (f)
    );

    assign cmd = f.verify_cmd | f.start | f.enter;

    logic            mode_bank;
    logic            mode_simple;
    logic            take_bank;
    logic            take_next;
    logic            need_prep;
    logic            prep_leave;
    logic            op_finish;
    logic            abort_req;
    logic [1:0]      result;
    remote_pkg::op_e cmd_kind;

    // an unused mode code behaves as standard: no banks, no areas, no reload
    assign mode_bank   = (mode == remote_pkg::MODE_BANK);
    assign mode_simple = (mode == remote_pkg::MODE_SIMPLE);

    // bank and area selects count only in their own mode
    assign take_bank = mode_bank & (f.bank != 3'h0);
    assign take_next = mode_simple & f.next;

    // a changed area is reloaded before the operation may start
    assign need_prep = mode_simple & area_changed;

    // reload ends on the core's word or when its window runs out
    assign prep_leave = prep_done | (r.cnt == PREP_LAST);

    // the core's result only counts while an operation runs
    assign op_finish = op_done & (r.st == remote_pkg::ST_BUSY);

    // cancel aborts a running operation but leaves busy to the core
    assign abort_req = f.cancel & (r.st == remote_pkg::ST_BUSY);

    // pass and error are one-hot by construction
    assign result = {op_pass, ~op_pass};

    // simultaneous commands: verify before start before enter
    always_comb begin
        if (f.verify_cmd) begin
            cmd_kind = remote_pkg::OP_VERIFY;
        end else if (f.start) begin
            cmd_kind = remote_pkg::OP_START;
        end else begin
            cmd_kind = remote_pkg::OP_ENTER;
        end
    end

    always_comb begin
        next_r           = r;
        next_r.link      = link_ready;
        next_r.op_start  = 1'b0;
        next_r.abort     = 1'b0;
        next_r.area_next = 1'b0;

        // clear drops whichever result is showing on the next edge
        if (f.clear) begin
            next_r.pass  = 1'b0; // R9
            next_r.error = 1'b0; // R9
        end

        unique case (r.st)
            remote_pkg::ST_IDLE: begin
                if (take_bank) begin
                    next_r.bank = f.bank;
                end
                if (take_next) begin
                    next_r.area_next = 1'b1;
                end
                // idle accepts at once, so a new command is never held off
                if (cmd) begin // R10
                    next_r.kind  = cmd_kind;
                    next_r.pass  = 1'b0;
                    next_r.error = 1'b0;
                    if (need_prep) begin
                        next_r.st       = remote_pkg::ST_PREP;
                        next_r.cnt      = '0;
                        next_r.prep_req = 1'b1;
                    end else begin
                        next_r.st       = remote_pkg::ST_BUSY;
                        next_r.busy     = 1'b1; // R3 R4 R6
                        next_r.op_start = 1'b1;
                    end
                end
            end
            remote_pkg::ST_PREP: begin
                next_r.cnt = r.cnt + 1'b1;
                if (f.cancel) begin
                    next_r.st       = remote_pkg::ST_IDLE;
                    next_r.prep_req = 1'b0;
                    next_r.error    = 1'b1;
                end else if (prep_leave) begin
                    // busy rises at the latest when the reload window runs out
                    next_r.st       = remote_pkg::ST_BUSY;
                    next_r.prep_req = 1'b0;
                    next_r.busy     = 1'b1; // R5
                    next_r.op_start = 1'b1;
                end
            end
            remote_pkg::ST_BUSY: begin
                if (abort_req) begin
                    next_r.abort = 1'b1;
                end
                // result wins over a clear in the same cycle
                if (op_finish) begin
                    next_r.st    = remote_pkg::ST_IDLE;
                    next_r.busy  = 1'b0;
                    next_r.pass  = result[1]; // R15
                    next_r.error = result[0]; // R15
                end
            end
            default: begin
                next_r.st       = remote_pkg::ST_IDLE;
                next_r.busy     = 1'b0;
                next_r.prep_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r      <= '0;
            r.st   <= remote_pkg::ST_IDLE;
            r.kind <= remote_pkg::OP_VERIFY;
            r.bank <= remote_pkg::BANK_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link_present = r.link;
    assign busy         = r.busy;
    assign pass         = r.pass;
    assign error        = r.error;
    assign op_start     = r.op_start;
    assign op_kind      = r.kind;
    assign op_bank      = r.bank;
    assign op_abort     = r.abort;
    assign area_next    = r.area_next;
    assign prep_req     = r.prep_req;

endmodule

// ---- rtl/remote_pkg.sv ----
package remote_pkg;

    // operating variant of the remote port
    typedef enum logic [1:0] {
        MODE_STANDARD = 2'h0,
        MODE_BANK     = 2'h1,
        MODE_SIMPLE   = 2'h2
    } mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PREP = 3'h2,
        ST_BUSY = 3'h4
    } state_e;

    typedef enum logic [1:0] {
        OP_VERIFY = 2'h0,
        OP_START  = 2'h1,
        OP_ENTER  = 2'h2
    } op_e;

    // one bit per remote strobe, high for one cycle on its falling edge
    typedef struct packed {
        logic       verify_cmd;
        logic       start;
        logic       enter;
        logic       cancel;
        logic       next;
        logic       clear;
        logic [2:0] bank;
    } strobe_s;

    localparam int unsigned STROBE_W = 9;

    // strobe pins idle high
    localparam logic [STROBE_W-1:0] STROBE_IDLE = 9'h1ff;

    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned PREP_MAX_MS = 8000;
    // longest time, rounded down to whole cycles
    localparam int unsigned PREP_MAX_CYCLES = PREP_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned PREP_CNT_W      = 28;

    localparam logic [2:0] BANK_RESET = 3'h1;

endpackage

// ---- rtl/strobe_edge.sv ----
`timescale 1ns/1ps

module strobe_edge #(
    parameter int unsigned N = remote_pkg::STROBE_W
) (
    input  wire logic         mclk,     // system clock
    input  wire logic         rst_n,    // synchronous reset, active low
    input  wire logic         enable,   // accept strobes only while the link is up
    input  wire logic [N-1:0] strobe_n, // active-low command strobes
    output logic      [N-1:0] fall      // one-cycle pulse per falling edge
);

    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] fall;
    } edge_s;

    edge_s        r;
    edge_s        next_r;
    logic [N-1:0] fell;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            assign fell[i] = r.prev[i] & ~strobe_n[i] & enable;
        end
    endgenerate

    always_comb begin
        next_r      = r;
        next_r.prev = strobe_n;
        next_r.fall = fell;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r.prev <= remote_pkg::STROBE_IDLE[N-1:0];
            r.fall <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign fall = r.fall;

endmodule
